//--- core/irq_enable_pkg.sv
package irq_enable_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_CLEAR_OFFSET = 8'h14;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_SET_OFFSET = 8'h18;
    localparam logic [ADDR_W-1:0] IRQ_FLAG_OFFSET = 8'h1c;
    localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [REG_W-1:0] ENABLE_IMPL_MASK = 16'h03fd;
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_FRAME_START = 2;
    localparam int BIT_END_OF_BUS_RESET = 3;
    localparam int BIT_WAKEUP = 4;
    localparam int BIT_END_OF_RESUME = 5;
    localparam int BIT_UPSTREAM_RESUME = 6;
    localparam int BIT_BUFFER_MEMORY_ACCESS_ERROR = 7;
    localparam int BIT_LINK_POWER_NOT_YET = 8;
    localparam int BIT_LINK_POWER_SUSPENDED = 9;
endpackage : irq_enable_pkg

//--- core/usb_device_irq_enable_pair.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module usb_device_irq_enable_pair
    import irq_enable_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [REG_W-1:0] irq_flag,
    output logic [REG_W-1:0] irq_request
);

    logic [REG_W-1:0] enable_reg;
    logic [REG_W-1:0] enable_next;
    logic [REG_W-1:0] lane_mask;
    logic [REG_W-1:0] set_bits;
    logic [REG_W-1:0] clear_bits;
    logic [DATA_W-1:0] read_next;
    logic access;
    logic write_strobe;
    logic hit_set;
    logic hit_clear;
    logic hit_flag;

    // The ack is held low in the cycle after it is given so that every access
    // takes exactly one wait state and a held request is never taken twice.
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign write_strobe = access && wb_we_i;
    assign hit_set = (wb_adr_i == IRQ_ENABLE_SET_OFFSET);
    assign hit_clear = (wb_adr_i == IRQ_ENABLE_CLEAR_OFFSET);
    assign hit_flag = (wb_adr_i == IRQ_FLAG_OFFSET);

    always_comb begin
        lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        set_bits = '0;
        clear_bits = '0;
        if (write_strobe && hit_set) begin
            set_bits = wb_dat_i[REG_W-1:0] & lane_mask & ENABLE_IMPL_MASK;
        end else if (write_strobe && hit_clear) begin
            clear_bits = wb_dat_i[REG_W-1:0] & lane_mask & ENABLE_IMPL_MASK;
        end
        // Zero bits in the written word leave enables alone.
        enable_next = (enable_reg | set_bits) & ~clear_bits;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            enable_reg <= ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    always_comb begin
        read_next = '0;
        if (hit_set || hit_clear) begin
            read_next = {{(DATA_W-REG_W){1'b0}}, enable_reg & ENABLE_IMPL_MASK};
        end else if (hit_flag) begin
            read_next = {{(DATA_W-REG_W){1'b0}}, irq_flag & ENABLE_IMPL_MASK};
        end else begin
            read_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wb_dat_o <= '0;
        end else if (access && !wb_we_i) begin
            wb_dat_o <= read_next;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi++) begin : g_req
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    irq_request[gi] <= 1'b0;
                end else begin
                    irq_request[gi] <= enable_next[gi] & irq_flag[gi] & ENABLE_IMPL_MASK[gi];
                end
            end
        end
    endgenerate

    property p_clear_drops;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[1] && wb_sel_i[0])
            |=> ((enable_reg & $past(wb_dat_i[REG_W-1:0])) == '0);
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("clear write left an enable set");

    property p_clear_susp;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_SUSPEND]) |=> !enable_reg[BIT_SUSPEND];
    endproperty
    a_clear_susp: assert property (p_clear_susp) else $error("suspend enable not cleared");

    property p_clear_lps;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[1] && wb_dat_i[BIT_LINK_POWER_SUSPENDED])
            |=> !enable_reg[BIT_LINK_POWER_SUSPENDED];
    endproperty
    a_clear_lps: assert property (p_clear_lps) else $error("link power suspended enable not cleared");

    property p_set_raises;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[1] && wb_sel_i[0])
            |=> ((enable_reg & $past(wb_dat_i[REG_W-1:0]) & ENABLE_IMPL_MASK)
                == ($past(wb_dat_i[REG_W-1:0]) & ENABLE_IMPL_MASK));
    endproperty
    a_set_raises: assert property (p_set_raises) else $error("set write missed an enable");

    property p_set_lps;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[1] && wb_dat_i[BIT_LINK_POWER_SUSPENDED])
            |=> enable_reg[BIT_LINK_POWER_SUSPENDED];
    endproperty
    a_set_lps: assert property (p_set_lps) else $error("link power suspended enable not set");

    property p_zero_keeps;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && (hit_set || hit_clear))
            |=> ((enable_reg & ~$past(wb_dat_i[REG_W-1:0])) == ($past(enable_reg) & ~$past(wb_dat_i[REG_W-1:0])));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed an enable");

    property p_request;
        @(posedge clock) disable iff (!resetn)
        ##1 (irq_request == (enable_reg & $past(irq_flag) & ENABLE_IMPL_MASK));
    endproperty
    a_request: assert property (p_request) else $error("interrupt request mismatch");

    property p_shared_read;
        @(posedge clock) disable iff (!resetn)
        (access && !wb_we_i && (hit_set || hit_clear))
            |=> (wb_ack_o && wb_dat_o[REG_W-1:0] == $past(enable_reg));
    endproperty
    a_shared_read: assert property (p_shared_read) else $error("enable readback mismatch");

    property p_unused_zero;
        @(posedge clock) disable iff (!resetn)
        (enable_reg & ~ENABLE_IMPL_MASK) == '0 && wb_dat_o[DATA_W-1:REG_W] == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_ack_once;
        @(posedge clock) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

    // Each source has its own check so that a fault in one bit position cannot hide behind the others.
    // The request is checked as well, since a flag that is already up must follow its enable at once.
    property p_clear_not_yet;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[1] && wb_dat_i[BIT_LINK_POWER_NOT_YET])
            |=> (!enable_reg[BIT_LINK_POWER_NOT_YET] && !irq_request[BIT_LINK_POWER_NOT_YET]);
    endproperty
    a_clear_not_yet: assert property (p_clear_not_yet) else $error("not-yet enable not cleared");

    property p_clear_mem_error;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_BUFFER_MEMORY_ACCESS_ERROR])
            |=> (!enable_reg[BIT_BUFFER_MEMORY_ACCESS_ERROR] && !irq_request[BIT_BUFFER_MEMORY_ACCESS_ERROR]);
    endproperty
    a_clear_mem_error: assert property (p_clear_mem_error) else $error("memory error enable not cleared");

    property p_clear_up_resume;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_UPSTREAM_RESUME])
            |=> (!enable_reg[BIT_UPSTREAM_RESUME] && !irq_request[BIT_UPSTREAM_RESUME]);
    endproperty
    a_clear_up_resume: assert property (p_clear_up_resume) else $error("upstream resume enable not cleared");

    property p_clear_end_resume;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_END_OF_RESUME])
            |=> (!enable_reg[BIT_END_OF_RESUME] && !irq_request[BIT_END_OF_RESUME]);
    endproperty
    a_clear_end_resume: assert property (p_clear_end_resume) else $error("end of resume enable not cleared");

    property p_clear_wakeup;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_WAKEUP])
            |=> (!enable_reg[BIT_WAKEUP] && !irq_request[BIT_WAKEUP]);
    endproperty
    a_clear_wakeup: assert property (p_clear_wakeup) else $error("wake-up enable not cleared");

    property p_clear_bus_reset_end;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_END_OF_BUS_RESET])
            |=> (!enable_reg[BIT_END_OF_BUS_RESET] && !irq_request[BIT_END_OF_BUS_RESET]);
    endproperty
    a_clear_bus_reset_end: assert property (p_clear_bus_reset_end) else $error("bus reset enable not cleared");

    property p_clear_frame_start;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_clear && wb_sel_i[0] && wb_dat_i[BIT_FRAME_START])
            |=> (!enable_reg[BIT_FRAME_START] && !irq_request[BIT_FRAME_START]);
    endproperty
    a_clear_frame_start: assert property (p_clear_frame_start) else $error("frame start enable not cleared");

    property p_set_not_yet;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[1] && wb_dat_i[BIT_LINK_POWER_NOT_YET])
            |=> (enable_reg[BIT_LINK_POWER_NOT_YET]
                && irq_request[BIT_LINK_POWER_NOT_YET] == $past(irq_flag[BIT_LINK_POWER_NOT_YET]));
    endproperty
    a_set_not_yet: assert property (p_set_not_yet) else $error("not-yet enable not set");

    property p_set_mem_error;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_BUFFER_MEMORY_ACCESS_ERROR])
            |=> (enable_reg[BIT_BUFFER_MEMORY_ACCESS_ERROR]
                && irq_request[BIT_BUFFER_MEMORY_ACCESS_ERROR] == $past(irq_flag[BIT_BUFFER_MEMORY_ACCESS_ERROR]));
    endproperty
    a_set_mem_error: assert property (p_set_mem_error) else $error("memory error enable not set");

    property p_set_up_resume;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_UPSTREAM_RESUME])
            |=> (enable_reg[BIT_UPSTREAM_RESUME]
                && irq_request[BIT_UPSTREAM_RESUME] == $past(irq_flag[BIT_UPSTREAM_RESUME]));
    endproperty
    a_set_up_resume: assert property (p_set_up_resume) else $error("upstream resume enable not set");

    property p_set_end_resume;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_END_OF_RESUME])
            |=> (enable_reg[BIT_END_OF_RESUME]
                && irq_request[BIT_END_OF_RESUME] == $past(irq_flag[BIT_END_OF_RESUME]));
    endproperty
    a_set_end_resume: assert property (p_set_end_resume) else $error("end of resume enable not set");

    property p_set_wakeup;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_WAKEUP])
            |=> (enable_reg[BIT_WAKEUP]
                && irq_request[BIT_WAKEUP] == $past(irq_flag[BIT_WAKEUP]));
    endproperty
    a_set_wakeup: assert property (p_set_wakeup) else $error("wake-up enable not set");

    property p_set_bus_reset_end;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_END_OF_BUS_RESET])
            |=> (enable_reg[BIT_END_OF_BUS_RESET]
                && irq_request[BIT_END_OF_BUS_RESET] == $past(irq_flag[BIT_END_OF_BUS_RESET]));
    endproperty
    a_set_bus_reset_end: assert property (p_set_bus_reset_end) else $error("bus reset enable not set");

    property p_set_frame_start;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_FRAME_START])
            |=> (enable_reg[BIT_FRAME_START]
                && irq_request[BIT_FRAME_START] == $past(irq_flag[BIT_FRAME_START]));
    endproperty
    a_set_frame_start: assert property (p_set_frame_start) else $error("frame start enable not set");

    property p_set_suspend;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && hit_set && wb_sel_i[0] && wb_dat_i[BIT_SUSPEND])
            |=> (enable_reg[BIT_SUSPEND]
                && irq_request[BIT_SUSPEND] == $past(irq_flag[BIT_SUSPEND]));
    endproperty
    a_set_suspend: assert property (p_set_suspend) else $error("suspend enable not set");

    property p_reset_zero;
        @(posedge clock)
        !resetn
            |=> (enable_reg == ENABLE_RESET && irq_request == '0 && !wb_ack_o && wb_dat_o == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");

    property p_ack_answers;
        @(posedge clock) disable iff (!resetn)
        access
            |=> wb_ack_o;
    endproperty
    a_ack_answers: assert property (p_ack_answers) else $error("request not answered in one cycle");

    property p_ack_needs_request;
        @(posedge clock) disable iff (!resetn)
        !(wb_cyc_i && wb_stb_i)
            |=> !wb_ack_o;
    endproperty
    a_ack_needs_request: assert property (p_ack_needs_request) else $error("ack without a request");

    property p_other_write_ignored;
        @(posedge clock) disable iff (!resetn)
        (write_strobe && !hit_set && !hit_clear)
            |=> (enable_reg == $past(enable_reg));
    endproperty
    a_other_write_ignored: assert property (p_other_write_ignored) else $error("foreign write changed an enable");

    property p_enable_quiet;
        @(posedge clock) disable iff (!resetn)
        !write_strobe
            |=> (enable_reg == $past(enable_reg));
    endproperty
    a_enable_quiet: assert property (p_enable_quiet) else $error("enable changed without a write");

    property p_unmapped_read;
        @(posedge clock) disable iff (!resetn)
        (access && !wb_we_i && !hit_set && !hit_clear && !hit_flag)
            |=> (wb_dat_o == '0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_flag_view;
        @(posedge clock) disable iff (!resetn)
        (access && !wb_we_i && hit_flag)
            |=> (wb_dat_o[REG_W-1:0] == ($past(irq_flag) & ENABLE_IMPL_MASK));
    endproperty
    a_flag_view: assert property (p_flag_view) else $error("flag view mismatch");

    property p_request_masked;
        @(posedge clock) disable iff (!resetn)
        ((irq_request & ~ENABLE_IMPL_MASK) == '0);
    endproperty
    a_request_masked: assert property (p_request_masked) else $error("request on an unused bit");

    property p_dat_stands;
        @(posedge clock) disable iff (!resetn)
        !(access && !wb_we_i)
            |=> $stable(wb_dat_o);
    endproperty
    a_dat_stands: assert property (p_dat_stands) else $error("read data changed without a read");

endmodule : usb_device_irq_enable_pair

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import irq_enable_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [DATA_W-1:0] wb_dat_i = '0;
    logic [DATA_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic [REG_W-1:0] irq_flag = 16'h0000;
    logic [REG_W-1:0] irq_request;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'hf72f;
    logic [31:0] r1, r2, r3;
    logic [REG_W-1:0] en_model = 16'h0000;
    logic [DATA_W-1:0] rd_queue[$];
    always #2.5 clock = ~clock;
    usb_device_irq_enable_pair usb_device_irq_enable_pair_inst (.clock(clock), .resetn(resetn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_flag(irq_flag),
        .irq_request(irq_request));
    task automatic compare(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : compare
    task automatic give_verdict;
        $display("checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic bus(input logic we, input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] d,
                       input logic [3:0] sel);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    task automatic rd(input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] exp);
        rd_queue.push_back(exp);
        bus(1'b0, adr, 32'h5a5a5a5a, 4'hf);
    endtask : rd
    // Only lanes 0 and 1 carry enables, and only implemented bits may change.
    task automatic wr(input logic set, input logic [DATA_W-1:0] d, input logic [3:0] sel);
        logic [REG_W-1:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}} & ENABLE_IMPL_MASK & d[15:0];
        bus(1'b1, set ? IRQ_ENABLE_SET_OFFSET : IRQ_ENABLE_CLEAR_OFFSET, d, sel);
        en_model = set ? (en_model | m) : (en_model & ~m);
    endtask : wr
    task automatic both_views;
        rd(IRQ_ENABLE_SET_OFFSET, {16'h0000, en_model});
        rd(IRQ_ENABLE_CLEAR_OFFSET, {16'h0000, en_model});
        @(posedge clock);
        @(negedge clock);
        compare({16'h0000, irq_request}, {16'h0000, en_model & irq_flag});
        // Returning on a rising edge lets the caller change inputs right after it.
        @(posedge clock);
    endtask : both_views
    // Read data is checked where the acknowledge is sampled, oldest note first.
    always @(posedge clock) begin
        cycles++;
        if (wb_cyc_i && wb_ack_o === 1'b1 && wb_we_i === 1'b0) compare(wb_dat_o, rd_queue.pop_front());
        if (cycles == 8000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        both_views();
        irq_flag <= 16'hffff;
        for (int p = 1; p >= 0; p--) begin
            for (int i = 0; i < REG_W; i++) begin
                wr(p[0], 32'h1 << i, 4'hf);
                both_views();
            end
        end
        repeat (60) begin
            r1 = $random(seed);
            r2 = $random(seed);
            r3 = $random(seed);
            irq_flag <= r1[15:0];
            wr(r3[4], r2, r3[3:0]);
            both_views();
        end
        bus(1'b1, IRQ_FLAG_OFFSET, 32'hffffffff, 4'hf);
        rd(IRQ_FLAG_OFFSET, {16'h0000, irq_flag & ENABLE_IMPL_MASK});
        rd(8'h40, 32'h0);
        wr(1'b0, 32'h0, 4'hf);
        both_views();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        en_model = 16'h0000;
        both_views();
        compare(rd_queue.size(), 32'h0);
        give_verdict();
    end
endmodule : testbench
